/* rtl/ifh_pkg.sv */
// Constants and types for the identify-word and idle command block.
// Assumes a 50 MHz device clock and a 32-bit plain register port.
package ifh_pkg;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned APD_UNIT_NS = 5000000; // One timer count, 5 ms
  localparam int unsigned APD_TICK_CYC = APD_UNIT_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 24;
  // Register byte addresses
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SEC = 8'h08;
  localparam logic [7:0] OFS_FEAT = 8'h0c;
  localparam logic [7:0] OFS_ERASE = 8'h10;
  localparam logic [7:0] OFS_MPW = 8'h14;
  localparam logic [7:0] OFS_LBA_LO = 8'h18;
  localparam logic [7:0] OFS_LBA_HI = 8'h1c;
  localparam logic [7:0] OFS_ALIGN = 8'h20;
  localparam logic [7:0] OFS_IDW_SEL = 8'h24;
  localparam logic [7:0] OFS_IDW_DATA = 8'h28;
  // Status register bits
  localparam int ST_BUSY_B = 0;
  localparam int ST_INTRQ_B = 1;
  localparam int ST_ERR_B = 2;
  localparam int ST_IDLE_B = 3;
  localparam int ST_DOWN_B = 4;
  localparam int ST_APD_B = 5;
  // Command codes
  localparam logic [7:0] CMD_IDLE_A = 8'h97;
  localparam logic [7:0] CMD_IDLE_B = 8'he3;
  localparam logic [7:0] CMD_IDLI_A = 8'h95;
  localparam logic [7:0] CMD_IDLI_B = 8'he1;
  localparam logic [7:0] CMD_SEC_UNLOCK = 8'hf2;
  localparam logic [7:0] CMD_SEC_ERASE = 8'hf4;
  // Identify word indices
  localparam logic [7:0] W85 = 8'h55;
  localparam logic [7:0] W86 = 8'h56;
  localparam logic [7:0] W87 = 8'h57;
  localparam logic [7:0] W88 = 8'h58;
  localparam logic [7:0] W89 = 8'h59;
  localparam logic [7:0] W92 = 8'h5c;
  localparam logic [7:0] W100 = 8'h64;
  localparam logic [7:0] W101 = 8'h65;
  localparam logic [7:0] W102 = 8'h66;
  localparam logic [7:0] W103 = 8'h67;
  localparam logic [7:0] W128 = 8'h80;
  localparam logic [7:0] W209 = 8'hd1;
  localparam logic [7:0] W217 = 8'hd9;
  // Identify word contents
  localparam logic [15:0] W85_FIXED = 16'h7008;
  localparam logic [15:0] W85_FIX_MASK = 16'h779d;
  localparam logic [15:0] W86_FIXED = 16'h0001;
  localparam logic [15:0] W87_VAL = 16'h4000;
  localparam logic [15:0] W217_VAL = 16'h0001;
  localparam int B85_SEC = 1;
  localparam int B85_WC = 5;
  localparam int B85_LA = 6;
  localparam int B86_APM = 3;
  localparam int B88_SEL = 8;
  localparam int B128_EXP = 4;
  localparam logic UDMA_SUP = 1'b1;
  localparam logic [2:0] UDMA_MAX = 3'h6;
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [47:0] RST_MAX_LBA = 48'h0000_0000_0000;

  typedef enum logic [2:0] {
    ST_READY = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } ifh_state_e;

  // Security state in word 128 order
  typedef struct packed {
    logic level_max;
    logic enh_erase;
    logic frozen;
    logic locked;
    logic enabled;
    logic supported;
  } ifh_sec_s;

  typedef struct packed {
    logic [2:0] udma_mode;
    logic udma_sel;
    logic apm;
    logic look_ahead;
    logic wr_cache;
  } ifh_feat_s;

  typedef struct packed {
    logic [7:0] count;
    logic [7:0] code;
  } ifh_cmd_s;
endpackage : ifh_pkg

/* rtl/ifh_apd_timer.sv */
// Automatic power-down countdown in 5 ms units.
// Assumes load, off and restart are single-cycle pulses, never together.
`timescale 1ns/10ps
module ifh_apd_timer
  import ifh_pkg::*;
#(
  parameter int unsigned TICK_CYC = APD_TICK_CYC
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [7:0] count,
  input wire logic off,
  input wire logic restart,
  output logic enabled,
  output logic expire
);
  logic [TICK_W-1:0] pre_q;
  logic [7:0] units_q;
  logic [7:0] reload_q;
  logic run_q;

  // Enable and reload value; count zero is never loaded
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      enabled <= 1'b0;
      reload_q <= 8'h00;
    end
    else if (off)
    begin
      enabled <= 1'b0;
    end
    else if (load)
    begin
      enabled <= 1'b1;
      reload_q <= count;
    end
  end

  // Countdown; it stops after expiry until a command restarts it
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pre_q <= '0;
      units_q <= 8'h00;
      run_q <= 1'b0;
      expire <= 1'b0;
    end
    else
    begin
      expire <= 1'b0;
      if (off)
      begin
        run_q <= 1'b0;
      end
      else if (load || (restart && enabled))
      begin
        units_q <= load ? count : reload_q;
        pre_q <= '0;
        run_q <= 1'b1;
      end
      else if (run_q)
      begin
        if (pre_q == TICK_W'(TICK_CYC - 1))
        begin
          pre_q <= '0;
          if (units_q == 8'h01)
          begin
            run_q <= 1'b0;
            expire <= 1'b1;
          end
          else
          begin
            units_q <= units_q - 8'h01;
          end
        end
        else
        begin
          pre_q <= pre_q + TICK_W'(1);
        end
      end
    end
  end
endmodule : ifh_apd_timer

/* rtl/ifh_top.sv */
// Identify feature words and idle command handling for a drive.
// Assumes a plain register port and a host that waits for busy to drop.
//
// Summary of operation
// - Word 87 reads 4000h: bit 14 one, bit 15 zero, rest reserved zero.
// - Word 85 bits 3, 12, 13, 14 always read one.
// - Word 85 bits 0, 2, 4, 7 to 10 read zero; 11 and 15 obsolete.
// - Word 85 bits 1, 5, 6 show security, write cache, look-ahead enabled.
// - Word 86 bit 0 one; bits 1, 2, 4 zero.
// - Word 86 bit 3 follows advanced power management enable.
// - Word 88 bits 14 to 8 flag at most one selected Ultra DMA mode.
// - Word 88 bits 6 to 0 report supported modes cumulatively.
// - Word 88 is zero without Ultra DMA; bits 15 and 7 read zero.
// - Word 89 gives erase unit time; host doubles it for minutes.
// - Word 92 returns the stored master password revision code.
// - Words 100 to 103 hold highest user block address plus one.
// - Word 128 bit 8 is one only when enabled at maximum level.
// - Expired attempt count sets word 128 bit 4, aborts unlock, erase.
// - Word 128 bits 5, 3, 2, 1, 0 show erase, frozen, lock, enable, support.
// - Word 209 gives block zero position within the first physical sector.
// - Word 217 reads one, meaning non-rotating media.
// - Idle codes raise busy, enter idle, then drop busy and raise interrupt in the same cycle.
// - Idle with nonzero count loads the 5 ms timer and enables it.
// - Idle with zero count disables automatic power-down.
// - Idle immediate does the same sequence, timer untouched.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/10ps
module ifh_top
  import ifh_pkg::*;
#(
  parameter int unsigned TICK_CYC = APD_TICK_CYC
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic dev_busy,
  output logic dev_intrq,
  output logic dev_err,
  output logic pwr_idle,
  output logic pwr_down
);
  ifh_state_e state_q;
  ifh_cmd_s cmd_q;
  ifh_cmd_s cmd_in;
  ifh_sec_s sec_q;
  ifh_feat_s feat_q;
  logic sec_exp_q;
  logic [15:0] erase_q;
  logic [15:0] mpw_q;
  logic [47:0] max_lba_q;
  logic [15:0] align_q;
  logic [7:0] idw_sel_q;
  logic accept;
  logic status_rd;
  logic apd_en;
  logic apd_expire;
  logic t_load;
  logic t_off;
  logic t_restart;
  logic [15:0] w85;
  logic [15:0] w86;
  logic [15:0] w88;
  logic [15:0] w128;
  logic [47:0] lba_p1;
  logic [15:0] id_word;

  // Idle command code check
  function automatic logic ifh_is_idle(input logic [7:0] code);
    return (code == CMD_IDLE_A) || (code == CMD_IDLE_B);
  endfunction : ifh_is_idle

  // Idle immediate command code check
  function automatic logic ifh_is_idli(input logic [7:0] code);
    return (code == CMD_IDLI_A) || (code == CMD_IDLI_B);
  endfunction : ifh_is_idli

  // Cumulative support mask up to a top mode
  function automatic logic [6:0] ifh_udma_mask(input logic [2:0] top);
    logic [6:0] m;
    m = 7'h00;
    for (int i = 0; i < 7; i++)
    begin
      m[i] = (3'(i) <= top);
    end
    return m;
  endfunction : ifh_udma_mask

  assign cmd_in = ifh_cmd_s'(reg_wdata[15:0]);
  // Commands written while busy are dropped, the host must poll busy first
  assign accept = reg_wr && (reg_addr == OFS_CMD) && (state_q == ST_READY);
  assign status_rd = reg_rd && (reg_addr == OFS_STATUS);

  // Timer control: idle loads or disables, idle immediate leaves it, other commands restart
  assign t_load = (state_q == ST_BUSY) && ifh_is_idle(cmd_q.code)
                  && (cmd_q.count != 8'h00);
  assign t_off = (state_q == ST_BUSY) && ifh_is_idle(cmd_q.code)
                 && (cmd_q.count == 8'h00);
  assign t_restart = accept && !ifh_is_idli(cmd_in.code)
                     && !ifh_is_idle(cmd_in.code);

  ifh_apd_timer #(
    .TICK_CYC(TICK_CYC)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(t_load),
    .count(cmd_q.count),
    .off(t_off),
    .restart(t_restart),
    .enabled(apd_en),
    .expire(apd_expire)
  );

  // Command sequencer: one busy phase, one finish phase
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_q <= ST_READY;
      cmd_q <= '0;
    end
    else
    begin
      case (state_q)
        ST_READY:
        begin
          if (accept)
          begin
            state_q <= ST_BUSY;
            cmd_q <= cmd_in;
          end
        end
        ST_BUSY:
        begin
          state_q <= ST_DONE;
        end
        ST_DONE:
        begin
          state_q <= ST_READY;
        end
        default:
        begin
          state_q <= ST_READY;
        end
      endcase
    end
  end

  // Busy covers both command phases, interrupt rises on the same edge as its release
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      dev_busy <= 1'b0;
      dev_intrq <= 1'b0;
    end
    else
    begin
      dev_busy <= accept || (state_q == ST_BUSY);
      if (state_q == ST_DONE)
      begin
        dev_intrq <= 1'b1;
      end
      else if (status_rd || accept)
      begin
        dev_intrq <= 1'b0;
      end
    end
  end

  // Abort status; security commands fail once the count has run out
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      dev_err <= 1'b0;
    end
    else if (state_q == ST_BUSY)
    begin
      dev_err <= sec_exp_q && ((cmd_q.code == CMD_SEC_UNLOCK)
                 || (cmd_q.code == CMD_SEC_ERASE));
    end
    else if (accept)
    begin
      dev_err <= 1'b0;
    end
  end

  // Power state; a command wakes the device, expiry loses to an accepted command and to an idle command's busy phase
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pwr_idle <= 1'b0;
      pwr_down <= 1'b0;
    end
    else if (accept)
    begin
      pwr_down <= 1'b0;
      pwr_idle <= 1'b0;
    end
    else if ((state_q == ST_BUSY)
             && (ifh_is_idle(cmd_q.code) || ifh_is_idli(cmd_q.code)))
    begin
      pwr_idle <= 1'b1;
      pwr_down <= 1'b0;
    end
    else if (apd_expire)
    begin
      pwr_down <= 1'b1;
      pwr_idle <= 1'b0;
    end
  end

  // Software-written configuration registers
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sec_q <= '0;
      feat_q <= '0;
      erase_q <= RST_WORD;
      mpw_q <= RST_WORD;
      max_lba_q <= RST_MAX_LBA;
      align_q <= RST_WORD;
      idw_sel_q <= 8'h00;
    end
    else if (reg_wr)
    begin
      if (reg_addr == OFS_SEC)
      begin
        sec_q <= {reg_wdata[8], reg_wdata[5], reg_wdata[3:0]};
      end
      else if (reg_addr == OFS_FEAT)
      begin
        feat_q <= ifh_feat_s'(reg_wdata[6:0]);
      end
      else if (reg_addr == OFS_ERASE)
      begin
        erase_q <= reg_wdata[15:0];
      end
      else if (reg_addr == OFS_MPW)
      begin
        mpw_q <= reg_wdata[15:0];
      end
      else if (reg_addr == OFS_LBA_LO)
      begin
        max_lba_q[31:0] <= reg_wdata;
      end
      else if (reg_addr == OFS_LBA_HI)
      begin
        max_lba_q[47:32] <= reg_wdata[15:0];
      end
      else if (reg_addr == OFS_ALIGN)
      begin
        align_q <= reg_wdata[15:0];
      end
      else if (reg_addr == OFS_IDW_SEL)
      begin
        idw_sel_q <= reg_wdata[7:0];
      end
    end
  end

  // Attempt count expiry is sticky until reset; writing zero has no effect
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sec_exp_q <= 1'b0;
    end
    else if (reg_wr && (reg_addr == OFS_SEC) && reg_wdata[B128_EXP])
    begin
      sec_exp_q <= 1'b1;
    end
  end

  // Identify words built from live state
  always_comb
  begin
    w85 = W85_FIXED;
    w85[B85_SEC] = sec_q.enabled;
    w85[B85_WC] = feat_q.wr_cache;
    w85[B85_LA] = feat_q.look_ahead;
    w86 = W86_FIXED;
    w86[B86_APM] = feat_q.apm;
    w88 = 16'h0000;
    if (UDMA_SUP)
    begin
      w88[6:0] = ifh_udma_mask(UDMA_MAX);
      // A mode beyond what is supported is never flagged as selected
      if (feat_q.udma_sel && (feat_q.udma_mode <= UDMA_MAX))
      begin
        w88[B88_SEL + int'(feat_q.udma_mode)] = 1'b1;
      end
    end
    w128 = {7'h00, sec_q.enabled && sec_q.level_max, 2'b00,
            sec_q.enh_erase, sec_exp_q, sec_q.frozen, sec_q.locked,
            sec_q.enabled, sec_q.supported};
  end

  // Capacity one past the highest block address, upper word always zero
  assign lba_p1 = max_lba_q + 48'h0000_0000_0001;

  // Identify word lookup; words outside this block read zero
  always_comb
  begin
    case (idw_sel_q)
      W85: id_word = w85;
      W86: id_word = w86;
      W87: id_word = W87_VAL;
      W88: id_word = w88;
      W89: id_word = erase_q;
      W92: id_word = mpw_q;
      W100: id_word = lba_p1[15:0];
      W101: id_word = lba_p1[31:16];
      W102: id_word = lba_p1[47:32];
      W103: id_word = 16'h0000;
      W128: id_word = w128;
      W209: id_word = align_q;
      W217: id_word = W217_VAL;
      default: id_word = 16'h0000;
    endcase
  end

  // Read data stand for exactly one cycle; unmapped addresses read zero
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else if (!reg_rd)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else if (reg_addr == OFS_STATUS)
    begin
      reg_rdata <= {16'h0000, cmd_q.count, 2'b00, apd_en, pwr_down,
                    pwr_idle, dev_err, dev_intrq, dev_busy};
    end
    else if (reg_addr == OFS_SEC)
    begin
      reg_rdata <= {16'h0000, w128};
    end
    else if (reg_addr == OFS_FEAT)
    begin
      reg_rdata <= {25'h0, feat_q};
    end
    else if (reg_addr == OFS_ERASE)
    begin
      reg_rdata <= {16'h0000, erase_q};
    end
    else if (reg_addr == OFS_MPW)
    begin
      reg_rdata <= {16'h0000, mpw_q};
    end
    else if (reg_addr == OFS_LBA_LO)
    begin
      reg_rdata <= max_lba_q[31:0];
    end
    else if (reg_addr == OFS_LBA_HI)
    begin
      reg_rdata <= {16'h0000, max_lba_q[47:32]};
    end
    else if (reg_addr == OFS_ALIGN)
    begin
      reg_rdata <= {16'h0000, align_q};
    end
    else if (reg_addr == OFS_IDW_SEL)
    begin
      reg_rdata <= {24'h000000, idw_sel_q};
    end
    else if (reg_addr == OFS_IDW_DATA)
    begin
      reg_rdata <= {16'h0000, id_word};
    end
    else
    begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Word 87 as seen on the read port
  property p_w87;
    reg_rd && (reg_addr == OFS_IDW_DATA) && (idw_sel_q == W87)
      |=> reg_rdata == {16'h0000, W87_VAL};
  endproperty
  a_w87: assert property (p_w87) else $error("word 87 wrong");

  property p_w85_fixed;
    (w85 & W85_FIX_MASK) == W85_FIXED;
  endproperty
  a_w85_fixed: assert property (p_w85_fixed) else $error("word 85 fixed bits");

  // Live bits checked where software sees them, not on the internal word
  property p_w85_live;
    reg_rd && (reg_addr == OFS_IDW_DATA) && (idw_sel_q == W85)
      |=> (reg_rdata[B85_SEC] == $past(sec_q.enabled))
      && (reg_rdata[B85_WC] == $past(feat_q.wr_cache))
      && (reg_rdata[B85_LA] == $past(feat_q.look_ahead));
  endproperty
  a_w85_live: assert property (p_w85_live) else $error("word 85 live bits");

  property p_w86;
    reg_rd && (reg_addr == OFS_IDW_DATA) && (idw_sel_q == W86)
      |=> reg_rdata == {16'h0000, W86_FIXED | {12'h000, $past(feat_q.apm), 3'b000}};
  endproperty
  a_w86: assert property (p_w86) else $error("word 86 wrong");

  property p_udma_sel;
    $onehot0(w88[14:8]) && !w88[15] && !w88[7];
  endproperty
  a_udma_sel: assert property (p_udma_sel) else $error("word 88 select");

  property p_udma_sup;
    (w88[6:0] & (w88[6:0] + 7'h01)) == 7'h00;
  endproperty
  a_udma_sup: assert property (p_udma_sup) else $error("word 88 support");

  property p_level;
    reg_rd && (reg_addr == OFS_IDW_DATA) && (idw_sel_q == W128)
      |=> reg_rdata[8] == ($past(sec_q.enabled) && $past(sec_q.level_max));
  endproperty
  a_level: assert property (p_level) else $error("word 128 level");

  property p_expired_abort;
    accept && sec_exp_q && (cmd_in.code == CMD_SEC_UNLOCK) |-> ##3 dev_err;
  endproperty
  a_expired_abort: assert property (p_expired_abort) else $error("no abort");

  property p_busy_seq;
    accept |=> dev_busy ##1 dev_busy ##1 (!dev_busy && dev_intrq);
  endproperty
  a_busy_seq: assert property (p_busy_seq) else $error("busy sequence");

  property p_apd_load;
    accept && ifh_is_idle(cmd_in.code) && (cmd_in.count != 8'h00) |-> ##2 apd_en;
  endproperty
  a_apd_load: assert property (p_apd_load) else $error("timer not on");

  property p_apd_off;
    accept && ifh_is_idle(cmd_in.code) && (cmd_in.count == 8'h00) |-> ##2 !apd_en;
  endproperty
  a_apd_off: assert property (p_apd_off) else $error("timer not off");

  property p_idli;
    accept && ifh_is_idli(cmd_in.code) |-> ##2 (apd_en == $past(apd_en, 2)) && pwr_idle;
  endproperty
  a_idli: assert property (p_idli) else $error("idle immediate");

  property p_powerdown;
    apd_expire && !accept && (state_q == ST_READY) |=> pwr_down && !pwr_idle;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("no power-down");
endmodule : ifh_top

/* tb/ifh_host_model.sv */
// Host adapter model: drives the plain register port of the drive.
// Assumes one shared clock; read data arrives in the cycle after the strobe.
`timescale 1ns/10ps
module ifh_host_model
  import ifh_pkg::*;
(
  input wire logic sys_clk,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  // Quiet bus at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One-cycle write; data inverted afterwards so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // One-cycle read; data taken only at the edge after the answer cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask : rd

  // Words left at 0000h or FFFFh by old drives mean nothing is indicated
  function automatic logic feat_valid(input logic [15:0] w);
    return (w != 16'h0000) && (w != 16'hffff);
  endfunction : feat_valid

  // Erase unit time in minutes, from the reported count
  function automatic int erase_min(input logic [15:0] w);
    return int'(w) * 2;
  endfunction : erase_min
endmodule : ifh_host_model

/* tb/tb_ifh_top.sv */
// Self-checking bench for the identify words and idle command handling.
// Assumes ifh_pkg and the host model; the 5 ms tick is shortened by TICK.
`timescale 1ns/10ps
module tb_ifh_top
  import ifh_pkg::*;
;
  localparam int unsigned TICK = 8;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic dev_busy;
  logic dev_intrq;
  logic dev_err;
  logic pwr_idle;
  logic pwr_down;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  logic [31:0] seed = 32'h3a30ea49;
  logic [31:0] rv;
  logic [6:0] feat = 7'h0;
  logic [8:0] sec = 9'h0;
  logic sec_exp = 1'b0;
  logic [15:0] erase;
  logic [15:0] mpw;
  logic [15:0] align;
  logic [47:0] lba;
  logic [7:0] ids [14] = '{W85, W86, W87, W88, W89, W92, W100, W101, W102, W103,
    W128, W209, W217, 8'h50};
  logic [15:0] cl [4] = '{16'h00e3, 16'hc897, 16'h0095, 16'h00e1};

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  ifh_top #(.TICK_CYC(TICK)) dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .dev_busy, .dev_intrq, .dev_err, .pwr_idle, .pwr_down);

  ifh_host_model host (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Expected identify word, built from the shadow configuration
  function automatic logic [15:0] exp_w(input logic [7:0] id);
    logic [47:0] p;
    p = lba + 48'h1;
    case (id)
      W85: return 16'h7008 | {9'h0, feat[1], feat[0], 3'h0, sec[1], 1'b0};
      W86: return {12'h0, feat[2], 3'h1};
      W87: return 16'h4000;
      W88: return 16'h007f | ((feat[3] && (feat[6:4] <= UDMA_MAX)) ?
        (16'h0100 << feat[6:4]) : 16'h0);
      W89: return erase;
      W92: return mpw;
      W100: return p[15:0];
      W101: return p[31:16];
      W102: return p[47:32];
      W128: return {7'h0, sec[8] & sec[1], 2'h0, sec[5], sec_exp, sec[3:0]};
      W209: return align;
      W217: return 16'h0001;
      default: return 16'h0;
    endcase
  endfunction : exp_w

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      num_errors++;
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // Command handshake: busy two cycles, then interrupt with the error flag
  task automatic run_cmd(input logic [7:0] code, input logic [7:0] cnt, input logic err);
    logic idl;
    idl = code inside {8'h97, 8'he3, 8'h95, 8'he1};
    host.wr(OFS_CMD, {16'h0, cnt, code});
    #1;
    check({31'h0, dev_busy}, 32'h1);
    @(posedge sys_clk);
    #1;
    check({30'h0, dev_busy, pwr_idle | ~idl}, 32'h3);
    @(posedge sys_clk);
    #1;
    check({29'h0, dev_busy, dev_intrq, dev_err}, {29'h0, 2'b01, err});
  endtask : run_cmd

  // Bounded wait for power-down; n holds the cycles spent
  task automatic wait_down(input int lim);
    n = 0;
    while (pwr_down !== 1'b1)
    begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > lim)
      begin
        num_errors++;
        results();
      end
    end
  endtask : wait_down

  task automatic read_word(input logic [7:0] id);
    host.wr(OFS_IDW_SEL, {24'h0, id});
    host.rd(OFS_IDW_DATA, rv);
    check(rv, {16'h0, exp_w(id)});
    if (id inside {W85, W86, W87})
      check({31'h0, host.feat_valid(rv[15:0])}, 32'h1);
    if (id == W89)
      check(32'(host.erase_min(rv[15:0])), {15'h0, erase, 1'b0});
  endtask : read_word

  // Main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    check({27'h0, dev_busy, dev_intrq, dev_err, pwr_idle, pwr_down}, 32'h0);
    // Random configurations, with corner values on the second pass
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      feat = {seed[26:24], seed[3:0]};
      sec = {seed[8], 2'b0, seed[5], 1'b0, seed[3:0]};
      erase = seed[31:16];
      seed = lfsr(seed);
      mpw = (i == 1) ? 16'hfffe : seed[15:0];
      align = seed[31:16];
      seed = lfsr(seed);
      lba = (i == 1) ? 48'hffff_ffff_fffe : {seed[15:0], lfsr(seed)};
      host.wr(OFS_FEAT, {25'h0, feat});
      host.wr(OFS_SEC, {23'h0, sec});
      host.wr(OFS_ERASE, {16'h0, erase});
      host.wr(OFS_MPW, {16'h0, mpw});
      host.wr(OFS_LBA_LO, lba[31:0]);
      host.wr(OFS_LBA_HI, {16'h0, lba[47:32]});
      host.wr(OFS_ALIGN, {16'h0, align});
      foreach (ids[k])
        read_word(ids[k]);
    end
    host.rd(8'h30, rv);
    check(rv, 32'h0);
    // All four idle codes; status shows idle, interrupt and timer enable
    foreach (cl[k])
    begin
      run_cmd(cl[k][7:0], cl[k][15:8], 1'b0);
      host.rd(OFS_STATUS, rv);
      check(rv & 32'h3f, {26'h0, k != 0, 5'b01010});
      check({31'h0, dev_intrq}, 32'h0);
    end
    // Second write lands in a busy cycle and must be dropped
    host.wr(OFS_CMD, 32'h0000_0597);
    host.wr(OFS_CMD, 32'h0000_0097);
    repeat (3) @(posedge sys_clk);
    host.rd(OFS_STATUS, rv);
    check(rv & 32'h20, 32'h20);
    // Count 2 expires after two ticks
    run_cmd(8'h97, 8'h02, 1'b0);
    wait_down(40);
    check({30'h0, n >= 13, n <= 19}, 32'h3);
    check({30'h0, pwr_down, pwr_idle}, 32'h2);
    run_cmd(8'h00, 8'h00, 1'b0);
    check({31'h0, pwr_down}, 32'h0);
    // Another command mid-count restarts the timer
    run_cmd(8'h97, 8'h02, 1'b0);
    repeat (8) @(posedge sys_clk);
    run_cmd(8'h00, 8'h00, 1'b0);
    wait_down(40);
    check({31'h0, n >= 12}, 32'h1);
    // Idle immediate leaves the running count alone
    run_cmd(8'h97, 8'h02, 1'b0);
    repeat (8) @(posedge sys_clk);
    run_cmd(8'h95, 8'h00, 1'b0);
    wait_down(40);
    check({31'h0, n <= 8}, 32'h1);
    // Zero count stops a running timer before it can expire
    run_cmd(8'h97, 8'h02, 1'b0);
    run_cmd(8'he3, 8'h00, 1'b0);
    repeat (40) @(posedge sys_clk);
    #1;
    check({31'h0, pwr_down}, 32'h0);
    // Expired attempt count: sticky, aborts unlock and erase unit only
    run_cmd(CMD_SEC_UNLOCK, 8'h00, 1'b0);
    host.wr(OFS_SEC, 32'h10);
    host.wr(OFS_SEC, 32'h0);
    sec = 9'h0;
    sec_exp = 1'b1;
    read_word(W128);
    run_cmd(CMD_SEC_UNLOCK, 8'h00, 1'b1);
    run_cmd(CMD_SEC_ERASE, 8'h00, 1'b1);
    run_cmd(8'h95, 8'h00, 1'b0);
    // Only a reset clears it
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    sec_exp = 1'b0;
    read_word(W128);
    results();
  end
endmodule : tb_ifh_top
